/* File: core/pvf_top.v */
// Register bank: manufacture date, output floor, per-phase limit.
// Assumes a PMBus front end that hands over decoded commands,
// one per cycle at most, and a VID source for output requests.
`timescale 1ns/1ps
`default_nettype none
`include "pvf_defines.vh"

module pvf_top
(
  input  wire        sys_clk,
  input  wire        rst,
  // Decoded PMBus command port
  input  wire        cmd_valid,
  input  wire        cmd_write,
  input  wire [7:0]  cmd_code,
  input  wire [15:0] cmd_wdata,
  output reg         rsp_valid_r,
  output reg  [15:0] rsp_rdata_r,
  output reg         rsp_unsup_r,
  // Nonvolatile store image
  input  wire        nvm_load,
  input  wire [7:0]  nvm_date_byte,
  input  wire        nvm_limit_valid,
  input  wire [3:0]  nvm_limit_code,
  output reg         nvm_store_r,
  output reg  [7:0]  nvm_store_date_r,
  // VID protocol selection
  input  wire        slew_mode_pin,
  input  wire        protocol_cfg_valid,
  input  wire        protocol_cfg,
  output reg         vid_protocol_r,
  // Output voltage request path
  input  wire        vout_req_valid,
  input  wire [7:0]  vout_req_vid,
  output reg         vout_cmd_valid_r,
  output reg  [7:0]  vout_cmd_vid_r,
  // Status and alert
  input  wire        status_clear,
  output reg         status_other_r,
  output reg         status_vout_r,
  output reg         alert_n_r,
  // Phase limit to the comparator
  input  wire [3:0]  current_limit_strap_pin,
  output reg  [3:0]  phase_current_limit_code_r,
  output reg  [6:0]  phase_limit_amps_r
);

  // Stored fields
  reg  [7:0]  date_writable_byte_r;  // Date high byte image
  reg  [7:0]  output_voltage_floor_r; // Floor VID code

  // Decoded strobes
  wire        wr_date;    // Date write this cycle
  wire        wr_floor;   // Floor write this cycle
  wire        wr_limit;   // Limit write this cycle
  wire        rd_any;     // Read this cycle
  wire        known;      // Code belongs to this bank

  // Clamp results for new requests and for floor raises
  wire [7:0]  req_out_vid; // Request after clamp
  wire        req_below;   // Request under floor
  wire [7:0]  cur_out_vid; // Held command after new floor
  wire        cur_below;   // Held command under new floor

  // Limit selector outputs
  wire [3:0]  lim_code;    // Active limit code
  wire [6:0]  lim_amps;    // Active threshold
  wire        lim_we;      // Override strobe
  wire [3:0]  lim_wcode;   // Override code

  // Next values
  reg  [15:0] rdata_nxt;   // Read data
  reg         warn_nxt;    // Below-floor attempt seen

  // Command decode, shared by read and write paths
  function pvf_hit;
    input [7:0] code;
    input [7:0] want;
    begin
      pvf_hit = (code == want);
    end
  endfunction

  assign known    = pvf_hit(cmd_code, `PVF_CMD_DATE)
                  | pvf_hit(cmd_code, `PVF_CMD_FLOOR)
                  | pvf_hit(cmd_code, `PVF_CMD_LIMIT);
  assign wr_date  = cmd_valid & cmd_write
                  & pvf_hit(cmd_code, `PVF_CMD_DATE);
  assign wr_floor = cmd_valid & cmd_write
                  & pvf_hit(cmd_code, `PVF_CMD_FLOOR);
  assign wr_limit = cmd_valid & cmd_write
                  & pvf_hit(cmd_code, `PVF_CMD_LIMIT);
  assign rd_any   = cmd_valid & ~cmd_write;

  // Clamp of a fresh request against the held floor
  pvf_floor_clamp
  #(
    .VID_W (8)
  )
  u_req_clamp
  (
    .req_vid   (vout_req_vid),
    .floor_vid (output_voltage_floor_r),
    .out_vid   (req_out_vid),
    .below     (req_below)
  );

  // Clamp of the held command against a floor being written
  pvf_floor_clamp
  #(
    .VID_W (8)
  )
  u_cur_clamp
  (
    .req_vid   (vout_cmd_vid_r),
    .floor_vid (cmd_wdata[7:0]),
    .out_vid   (cur_out_vid),
    .below     (cur_below)
  );

  // NVM restore counts as an override of the strap as well
  assign lim_we    = wr_limit | (nvm_load & nvm_limit_valid);
  assign lim_wcode = wr_limit
                   ? cmd_wdata[`PVF_LIMIT_MSB:`PVF_LIMIT_LSB]
                   : nvm_limit_code;

  // Limit source selection and threshold mapping
  pvf_limit_sel u_limit
  (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .strap_code (current_limit_strap_pin),
    .ovr_we     (lim_we),
    .ovr_code   (lim_wcode),
    .code_r     (lim_code),
    .amps_r     (lim_amps)
  );

  // Read mux; fixed and reserved bytes are constants
  always @*
  begin
    rdata_nxt = 16'h0000;
    case (cmd_code)
      `PVF_CMD_DATE:
        rdata_nxt = {date_writable_byte_r,
                     `PVF_DATE_FIXED};
      `PVF_CMD_FLOOR:
        rdata_nxt = {`PVF_FLOOR_HI_FIXED,
                     output_voltage_floor_r};
      `PVF_CMD_LIMIT:
        rdata_nxt = {8'h00, `PVF_LIMIT_HI_FIXED, lim_code};
      default:
        rdata_nxt = 16'h0000;
    endcase
  end

  // A request under the floor is the only warning source here
  always @*
  begin
    warn_nxt = vout_req_valid & req_below;
  end

  // Command answers, one cycle after the command
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= 16'h0000;
      rsp_unsup_r <= 1'b0;
    end
    else
    begin
      rsp_valid_r <= cmd_valid;
      rsp_unsup_r <= cmd_valid & ~known;
      // Hold last data, so a write does not disturb it
      if (rd_any)
        rsp_rdata_r <= rdata_nxt;
    end
  end

  // Date byte: restored from NVM, written by block write
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      date_writable_byte_r <= `PVF_DATE_WR_RST;
      nvm_store_r          <= 1'b0;
      nvm_store_date_r     <= `PVF_DATE_WR_RST;
    end
    else
    begin
      nvm_store_r <= wr_date;
      // Host write wins over a restore in the same cycle
      if (wr_date)
      begin
        // Low byte is fixed, so its data is dropped
        date_writable_byte_r <=
          cmd_wdata[`PVF_DATE_WR_MSB:`PVF_DATE_WR_LSB];
        nvm_store_date_r     <=
          cmd_wdata[`PVF_DATE_WR_MSB:`PVF_DATE_WR_LSB];
      end
      else if (nvm_load)
        date_writable_byte_r <= nvm_date_byte;
    end
  end

  // Floor register; high byte is never stored
  always @(posedge sys_clk)
  begin
    if (rst)
      output_voltage_floor_r <= `PVF_FLOOR_RST;
    else if (wr_floor)
      output_voltage_floor_r <= cmd_wdata[7:0];
  end

  // Active VID table: config input beats the strap pin while protocol_cfg_valid is high
  always @(posedge sys_clk)
  begin
    if (rst)
      vid_protocol_r <= 1'b0;
    else if (protocol_cfg_valid)
      vid_protocol_r <= protocol_cfg;
    else
      vid_protocol_r <= slew_mode_pin;
  end

  // Commanded VID; a request is clamped to the held floor, even in the cycle a new floor is written
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      vout_cmd_valid_r <= 1'b0;
      vout_cmd_vid_r   <= `PVF_FLOOR_RST;
    end
    else
    begin
      vout_cmd_valid_r <= 1'b0;
      if (vout_req_valid)
      begin
        // Request compared and clamped in one step
        vout_cmd_vid_r   <= req_out_vid;
        vout_cmd_valid_r <= 1'b1;
      end
      else if (wr_floor & cur_below)
      begin
        // Raised floor pulls a held command up with it
        vout_cmd_vid_r   <= cur_out_vid;
        vout_cmd_valid_r <= 1'b1;
      end
    end
  end

  // Sticky status bits; a new warning beats a clear
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      status_other_r <= 1'b0;
      status_vout_r  <= 1'b0;
    end
    else
    begin
      if (warn_nxt)
      begin
        status_other_r <= 1'b1;
        status_vout_r  <= 1'b1;
      end
      else if (status_clear)
      begin
        status_other_r <= 1'b0;
        status_vout_r  <= 1'b0;
      end
    end
  end

  // Alert follows the warning; no fault or shutdown output exists
  always @(posedge sys_clk)
  begin
    if (rst)
      alert_n_r <= 1'b1;
    else if (warn_nxt)
      alert_n_r <= 1'b0;
    else if (status_clear)
      alert_n_r <= 1'b1;
  end

  // Limit outputs registered again at the top boundary
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      phase_current_limit_code_r <= `PVF_LIMIT_NVM_RST;
      phase_limit_amps_r         <= `PVF_LIMIT_AMPS_RST;
    end
    else
    begin
      phase_current_limit_code_r <= lim_code;
      phase_limit_amps_r         <= lim_amps;
    end
  end

endmodule

`default_nettype wire

/* File: core/pvf_defines.vh */
// Constants for the output floor, date and phase limit register bank.
// Assumes a command-level PMBus front end outside this bank.
// How it works
// - Date high byte writable, kept nonvolatile; low fixed
// - Floor bounds commanded output, but a request in a floor write cycle is held to the old floor
// - Request below floor becomes the floor
// - Below-floor request warns, never faults
// - Below-floor request sets status byte other
// - Below-floor request sets status word vout
// - Below-floor request asserts the alert line
// - Floor is two bytes, high reserved zero
// - Floor code uses active VID protocol table
// - Limit code 0 is 24A, +3A each
// - Strap gives limit; PMBus write overrides; default 08h
`ifndef PVF_DEFINES_VH
`define PVF_DEFINES_VH

// Command codes of this bank
`define PVF_CMD_DATE        8'h9d
`define PVF_CMD_FLOOR       8'ha4
`define PVF_CMD_LIMIT       8'hd0

// Date register layout
`define PVF_DATE_WR_MSB     15
`define PVF_DATE_WR_LSB     8
`define PVF_DATE_FIXED      8'h01
`define PVF_DATE_WR_RST     8'h00

// Floor register layout and reset
`define PVF_FLOOR_RST       8'h00
`define PVF_FLOOR_HI_FIXED  8'h00

// Phase limit register layout and reset
`define PVF_LIMIT_MSB       3
`define PVF_LIMIT_LSB       0
`define PVF_LIMIT_NVM_RST   4'h8
`define PVF_LIMIT_HI_FIXED  4'h0
`define PVF_LIMIT_AMPS_RST  7'h30

// Threshold mapping in amperes
`define PVF_LIMIT_BASE_A    7'h18
`define PVF_LIMIT_STEP_A    7'h03

`endif

/* File: core/pvf_floor_clamp.v */
// Floor comparator and clamp for requested output VID codes.
// Assumes request and floor codes use the same active VID table.
`timescale 1ns/1ps
`default_nettype none

module pvf_floor_clamp
#(
  parameter VID_W = 8
)
(
  input  wire [VID_W-1:0] req_vid,
  input  wire [VID_W-1:0] floor_vid,
  output wire [VID_W-1:0] out_vid,
  output wire             below
);

  // Codes rise with voltage in both tables, so code order is enough
  assign below   = (req_vid < floor_vid);
  // Substitute the floor in the same cycle as the compare
  assign out_vid = below ? floor_vid : req_vid;

endmodule

`default_nettype wire

/* File: core/pvf_limit_sel.v */
// Per-phase valley limit source selection and amp mapping.
// Assumes strap level is stable around reset release.
`timescale 1ns/1ps
`default_nettype none
`include "pvf_defines.vh"

module pvf_limit_sel
(
  input  wire       sys_clk,
  input  wire       rst,
  input  wire [3:0] strap_code,
  input  wire       ovr_we,
  input  wire [3:0] ovr_code,
  output reg  [3:0] code_r,
  output reg  [6:0] amps_r
);

  reg       strap_pend_r;   // Strap not yet captured
  reg [3:0] code_nxt;       // Next active code

  // Threshold in amperes, linear over all sixteen codes
  function [6:0] pvf_amps;
    input [3:0] c;
    begin
      pvf_amps = `PVF_LIMIT_BASE_A
               + ({3'h0, c} * `PVF_LIMIT_STEP_A);
    end
  endfunction

  // Pick strap once, later override wins
  always @*
  begin
    code_nxt = code_r;
    if (ovr_we)
      code_nxt = ovr_code;
    else if (strap_pend_r)
      code_nxt = strap_code;
  end

  // Strap is caught on the first edge after reset release
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      strap_pend_r <= 1'b1;
      code_r       <= `PVF_LIMIT_NVM_RST;
      amps_r       <= `PVF_LIMIT_AMPS_RST;
    end
    else
    begin
      strap_pend_r <= 1'b0;
      code_r       <= code_nxt;
      amps_r       <= pvf_amps(code_nxt);
    end
  end

endmodule

`default_nettype wire

/* File: dv/pvf_props.sv */
// Checker for the date, floor and phase limit bank.
// Sees only the top ports; bound to pvf_top below.
`timescale 1ns/1ps
`default_nettype none
`include "pvf_defines.vh"
module pvf_props
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] rsp_rdata_r,
  input wire logic        nvm_store_r,
  input wire logic [7:0]  nvm_store_date_r,
  input wire logic        vout_req_valid,
  input wire logic [7:0]  vout_req_vid,
  input wire logic        vout_cmd_valid_r,
  input wire logic [7:0]  vout_cmd_vid_r,
  input wire logic        status_clear,
  input wire logic        status_other_r,
  input wire logic        status_vout_r,
  input wire logic        alert_n_r,
  input wire logic [3:0]  phase_current_limit_code_r,
  input wire logic [6:0]  phase_limit_amps_r
);
  logic [7:0] floor_r; // Shadow copy of the floor
  wire        wr = cmd_valid && cmd_write;
  wire        rd = cmd_valid && !cmd_write;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Shadow follows host floor writes
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      floor_r <= 8'h00;
    else if (wr && cmd_code == `PVF_CMD_FLOOR)
      floor_r <= cmd_wdata[7:0];
  end
  sequence s_below;
    vout_req_valid && vout_req_vid < floor_r;
  endsequence
  sequence s_ok_req;
    vout_req_valid && vout_req_vid >= floor_r;
  endsequence
  property p_bound;
    vout_cmd_valid_r |-> vout_cmd_vid_r >= $past(floor_r);
  endproperty
  property p_sub;
    s_below |=> vout_cmd_valid_r && vout_cmd_vid_r == $past(floor_r);
  endproperty
  property p_pass;
    s_ok_req |=> vout_cmd_valid_r && vout_cmd_vid_r == $past(vout_req_vid);
  endproperty
  property p_status;
    s_below |=> status_other_r && status_vout_r;
  endproperty
  property p_alert;
    s_below |=> !alert_n_r;
  endproperty
  // Warning stays latched; only a status clear releases it
  property p_hold;
    !alert_n_r && !status_clear |=> !alert_n_r && status_other_r;
  endproperty
  property p_date;
    wr && cmd_code == `PVF_CMD_DATE |=>
      nvm_store_r && nvm_store_date_r == $past(cmd_wdata[15:8]);
  endproperty
  property p_floor_rd;
    rd && cmd_code == `PVF_CMD_FLOOR |=> rsp_rdata_r == {8'h00, floor_r};
  endproperty
  property p_amps;
    phase_limit_amps_r == `PVF_LIMIT_BASE_A +
      `PVF_LIMIT_STEP_A * {3'h0, phase_current_limit_code_r};
  endproperty
  property p_limit;
    wr && cmd_code == `PVF_CMD_LIMIT |=> ##1
      phase_current_limit_code_r == $past(cmd_wdata[3:0], 2);
  endproperty
  a_bound: assert property (p_bound) else $error("floor not kept");
  a_sub: assert property (p_sub) else $error("no floor substitute");
  a_pass: assert property (p_pass) else $error("request altered");
  a_status: assert property (p_status) else $error("status unset");
  a_alert: assert property (p_alert) else $error("alert not raised");
  a_hold: assert property (p_hold) else $error("warning lost");
  a_date: assert property (p_date) else $error("date not stored");
  a_floor_rd: assert property (p_floor_rd) else $error("floor read bad");
  a_amps: assert property (p_amps) else $error("amps mapping bad");
  a_limit: assert property (p_limit) else $error("limit not taken");
endmodule
bind pvf_top pvf_props i_pvf_props (.sys_clk(sys_clk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
  .cmd_wdata(cmd_wdata), .rsp_rdata_r(rsp_rdata_r),
  .nvm_store_r(nvm_store_r), .nvm_store_date_r(nvm_store_date_r),
  .vout_req_valid(vout_req_valid), .vout_req_vid(vout_req_vid),
  .vout_cmd_valid_r(vout_cmd_valid_r), .vout_cmd_vid_r(vout_cmd_vid_r),
  .status_clear(status_clear), .status_other_r(status_other_r),
  .status_vout_r(status_vout_r), .alert_n_r(alert_n_r),
  .phase_current_limit_code_r(phase_current_limit_code_r),
  .phase_limit_amps_r(phase_limit_amps_r));
`default_nettype wire

/* File: dv/pvf_host_model.sv */
// Host side model issuing decoded commands to the bank.
// Assumes the answer arrives one edge after the command.
`timescale 1ns/1ps
`default_nettype none
`include "pvf_defines.vh"
module pvf_host_model
(
  input  wire logic        sys_clk,
  output var  logic        cmd_valid,
  output var  logic        cmd_write,
  output var  logic [7:0]  cmd_code,
  output var  logic [15:0] cmd_wdata,
  input  wire logic        rsp_valid_r,
  input  wire logic [15:0] rsp_rdata_r,
  input  wire logic        rsp_unsup_r
);
  logic date_done; // Date already programmed
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    date_done = 1'b0;
  end
  // One command; a second date write is sent as a read instead
  task xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
            output logic ok, output logic [15:0] q, output logic u);
  begin
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w && !(c == `PVF_CMD_DATE && date_done);
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge sys_clk);
    if (w && c == `PVF_CMD_DATE)
      date_done = 1'b1;
    cmd_valid <= 1'b0;
    cmd_code <= ~c; // Released lines do not keep old values
    cmd_wdata <= ~d;
    #1;
    ok = rsp_valid_r;
    q = rsp_rdata_r;
    u = rsp_unsup_r;
  end
  endtask
endmodule
`default_nettype wire

/* File: dv/pmbus_vout_floor_and_phase_ocl_regs_tb.sv */
// Testbench for the date, floor and phase limit bank.
// Assumes the host model drives the command port.
`timescale 1ns/1ps
`default_nettype none
`include "pvf_defines.vh"
module pmbus_vout_floor_and_phase_ocl_regs_tb;
  logic        sys_clk, rst, nvm_load, nvm_limit_valid, slew_mode_pin;
  logic        protocol_cfg_valid, protocol_cfg, vout_req_valid;
  logic        status_clear, ok, u;
  logic [7:0]  nvm_date_byte, vout_req_vid;
  logic [3:0]  nvm_limit_code, strap;
  logic [15:0] q;
  wire  logic  cmd_valid, cmd_write, rsp_valid_r, rsp_unsup_r, nvm_store_r;
  wire  logic  vid_protocol_r, vout_cmd_valid_r, status_other_r;
  wire  logic  status_vout_r, alert_n_r;
  wire  logic [7:0]  cmd_code, nvm_store_date_r, vout_cmd_vid_r;
  wire  logic [15:0] cmd_wdata, rsp_rdata_r;
  wire  logic [3:0]  lim;
  wire  logic [6:0]  amps;
  int          fails, tests_run, i;
  pvf_top i_pvf_top (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid_r(rsp_valid_r), .rsp_rdata_r(rsp_rdata_r),
    .rsp_unsup_r(rsp_unsup_r), .nvm_load(nvm_load),
    .nvm_date_byte(nvm_date_byte), .nvm_limit_valid(nvm_limit_valid),
    .nvm_limit_code(nvm_limit_code), .nvm_store_r(nvm_store_r),
    .nvm_store_date_r(nvm_store_date_r), .slew_mode_pin(slew_mode_pin),
    .protocol_cfg_valid(protocol_cfg_valid), .protocol_cfg(protocol_cfg),
    .vid_protocol_r(vid_protocol_r), .vout_req_valid(vout_req_valid),
    .vout_req_vid(vout_req_vid), .vout_cmd_valid_r(vout_cmd_valid_r),
    .vout_cmd_vid_r(vout_cmd_vid_r), .status_clear(status_clear),
    .status_other_r(status_other_r), .status_vout_r(status_vout_r),
    .alert_n_r(alert_n_r), .current_limit_strap_pin(strap),
    .phase_current_limit_code_r(lim), .phase_limit_amps_r(amps));
  pvf_host_model i_pvf_host_model (.sys_clk(sys_clk),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_valid_r(rsp_valid_r),
    .rsp_rdata_r(rsp_rdata_r), .rsp_unsup_r(rsp_unsup_r));
  always #20 sys_clk = ~sys_clk;
  task stop_test;
  begin
    $display("TB: %0d compares, %0d mismatches", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
  begin
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  end
  endtask
  task wr(input logic [7:0] c, input logic [15:0] d);
    i_pvf_host_model.xfer(1'b1, c, d, ok, q, u);
    check({14'h0000, ok, u}, 16'h0002);
  endtask
  task rd(input logic [7:0] c, input logic [15:0] e, input logic eu);
    i_pvf_host_model.xfer(1'b0, c, d_none(), ok, q, u);
    check(q, e);
    check({14'h0000, ok, u}, {14'h0000, 1'b1, eu});
  endtask
  function logic [15:0] d_none();
    return 16'h5a5a;
  endfunction
  // Request, then compare warning state and commanded code
  task vreq(input logic [7:0] v, input logic [7:0] e, input logic w);
    @(posedge sys_clk);
    vout_req_valid <= 1'b1;
    vout_req_vid <= v;
    @(posedge sys_clk);
    vout_req_valid <= 1'b0;
    vout_req_vid <= ~v;
    #1;
    check({alert_n_r, status_other_r, status_vout_r, vout_cmd_valid_r,
           4'h0, vout_cmd_vid_r}, {~w, w, w, 1'b1, 4'h0, e});
  endtask
  task lim_is(input logic [3:0] c);
    check({5'h00, amps, lim}, {5'h00, `PVF_LIMIT_BASE_A +
          `PVF_LIMIT_STEP_A * {3'h0, c}, c});
  endtask
  initial
  begin
    #200000;
    fails++;
    stop_test;
  end
  initial
  begin
    {sys_clk, nvm_load, nvm_limit_valid, slew_mode_pin} = 4'h0;
    {protocol_cfg_valid, protocol_cfg, vout_req_valid, status_clear} = 4'h0;
    {nvm_date_byte, vout_req_vid, nvm_limit_code} = 20'h0_0000;
    {rst, strap} = 5'h15;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    lim_is(4'h5);
    rd(`PVF_CMD_DATE, 16'h0001, 1'b0);
    wr(`PVF_CMD_DATE, 16'ha5ff);
    check({nvm_store_r, 7'h00, nvm_store_date_r}, 16'h80a5);
    wr(`PVF_CMD_DATE, 16'h1101);
    rd(`PVF_CMD_DATE, 16'ha501, 1'b0);
    @(posedge sys_clk);
    {nvm_load, nvm_limit_valid, nvm_date_byte, nvm_limit_code} <= 14'h33cc;
    @(posedge sys_clk);
    nvm_load <= 1'b0;
    rd(`PVF_CMD_DATE, 16'h3c01, 1'b0);
    lim_is(4'hc);
    $display("TB: date test done");
    wr(`PVF_CMD_FLOOR, 16'hff40);
    rd(`PVF_CMD_FLOOR, 16'h0040, 1'b0);
    vreq(8'h50, 8'h50, 1'b0);
    vreq(8'h3f, 8'h40, 1'b1);
    vreq(8'h40, 8'h40, 1'b1);
    @(posedge sys_clk);
    status_clear <= 1'b1;
    @(posedge sys_clk);
    status_clear <= 1'b0;
    #1;
    // Clear must drop the alert and both status bits together
    check({13'h0000, alert_n_r, status_other_r, status_vout_r},
          16'h0004);
    wr(`PVF_CMD_FLOOR, 16'h0060);
    check({vout_cmd_valid_r, alert_n_r, 6'h00, vout_cmd_vid_r},
          16'hc060);
    vreq(8'h00, 8'h60, 1'b1);
    $display("TB: floor test done");
    for (i = 0; i < 16; i++)
    begin
      wr(`PVF_CMD_LIMIT, {12'habc, i[3:0]});
      @(posedge sys_clk);
      #1;
      lim_is(i[3:0]);
      rd(`PVF_CMD_LIMIT, {12'h000, i[3:0]}, 1'b0);
    end
    for (i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      {protocol_cfg_valid, protocol_cfg, slew_mode_pin} <= {i[1:0], ~i[0]};
      repeat (2) @(posedge sys_clk);
      #1;
      check({15'h0000, vid_protocol_r}, {15'h0000, i[1] ~^ i[0]});
    end
    rd(8'h9e, 16'h0000, 1'b1);
    $display("TB: limit and select tests done");
    stop_test;
  end
endmodule
`default_nettype wire
